// ===== logic/mcf_consts.svh
// Purpose: offsets, fields and reset values for the memory-unit control block
// Assumes: 32-bit axi4-lite register bus, one aligned word per register
// Notes: byte addresses below are the block's own map
`ifndef MCF_CONSTS_SVH
`define MCF_CONSTS_SVH
`define MCF_OFF_FLUSH_NG 8'h00
`define MCF_OFF_FLUSH_ALL 8'h04
`define MCF_OFF_FLUSH_ONE_LO 8'h08
`define MCF_OFF_FLUSH_ONE_HI 8'h0c
`define MCF_OFF_SPACE_NUM 8'h10
`define MCF_OFF_MEM_CTRL 8'h14
`define MCF_OFF_CACHE_MODE 8'h18
`define MCF_OFF_TLB_LOAD 8'h1c
`define MCF_OFF_STATUS 8'h20
`define MCF_TLB_ENTRIES 64
`define MCF_MC_BIG_END 0
`define MCF_MC_SP0 1
`define MCF_MC_SP1 2
`define MCF_MC_EBOX_BIG 4
`define MCF_CM_ENA 0
`define MCF_CM_FHIT 1
`define MCF_CM_BADPAR 2
`define MCF_CM_PERR_OFF 3
`define MCF_MC_RESET 6'h00
`define MCF_CM_RESET 4'h0
`define MCF_SP1_TAG 2'h2
`define MCF_SP0_TAG 13'h1ffe
`define MCF_RESP_OKAY 2'h0
`define MCF_RESP_SLVERR 2'h2
`endif

// ===== logic/mcf_pkg.sv
// Purpose: types for the memory-unit control block
// Assumes: nothing beyond the constants header
// Notes: response codes live in the header
package mcf_pkg;
    typedef enum logic [2:0] {
        MCF_IDLE = 3'b001,
        MCF_WRESP = 3'b010,
        MCF_HOLD = 3'b100
    } mcf_wr_state_t;
endpackage : mcf_pkg

// ===== logic/mcf_memctl.sv
// Purpose: data-TLB flushes, memory control and l1 cache mode registers
// Assumes: registers written by privileged software over axi4-lite
// Notes: entries are loaded by a simple software port to make the tlb observable
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`include "mcf_consts.svh"
module mcf_memctl
    import mcf_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic timeout_reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic flush_abort,
    input wire logic [42:0] lookup_va,
    input wire logic lookup_kernel,
    input wire logic lookup_longword,
    output logic lookup_hit,
    output logic lookup_superpage,
    output logic [39:0] lookup_pa,
    input wire logic [63:0] vptb_base,
    input wire logic [42:0] fault_va,
    output logic [63:0] formatted_fault_address,
    output logic ebox_big_endian,
    input wire logic cache_hw_disable,
    output logic cache_active,
    output logic cache_force_hit,
    output logic parity_corrupt_inject,
    input wire logic parity_err_raw,
    output logic parity_err_report
);
    localparam int NE = `MCF_TLB_ENTRIES;

    logic [5:0] mem_ctrl_q;
    logic [3:0] cache_mode_q;
    logic [6:0] space_number_q;
    logic [31:0] one_lo_q;
    logic [5:0] victim_q;
    logic [NE-1:0] valid_q;
    logic [NE-1:0] glob_q;
    logic [29:0] vpn_q [NE];
    logic [6:0] ent_space_q [NE];
    logic [26:0] pfn_q [NE];
    logic [NE-1:0] hit_vec;
    logic [NE-1:0] one_match;
    mcf_wr_state_t wst_q;
    logic [7:0] aw_q;
    logic [31:0] w_q;
    logic aw_have_q, w_have_q;
    logic wstrb0_q; // low strobe kept with the data, the master may drop it after the w handshake
    logic wr_fire, wr_mapped;
    logic fl_ng, fl_all, fl_one, ld_ent;
    logic [29:0] one_vpn;
    logic ab_s1_q, ab_s2_q, hd_s1_q, hd_s2_q;

    // two-flop sync of pipeline abort and hardware disable pins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ab_s1_q <= 1'b0;
            ab_s2_q <= 1'b0;
            hd_s1_q <= 1'b0;
            hd_s2_q <= 1'b0;
        end else begin
            ab_s1_q <= flush_abort;
            ab_s2_q <= ab_s1_q;
            hd_s1_q <= cache_hw_disable;
            hd_s2_q <= hd_s1_q;
        end
    end

    // write channels captured in either order, answered after both
    assign s_axi_awready = (wst_q == MCF_IDLE) && !aw_have_q;
    assign s_axi_wready = (wst_q == MCF_IDLE) && !w_have_q;
    assign wr_fire = (wst_q == MCF_IDLE) && aw_have_q && w_have_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wst_q <= MCF_IDLE;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_q <= 8'h00;
            w_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MCF_RESP_OKAY;
        end else begin
            case (wst_q)
                MCF_IDLE: begin
                    if (s_axi_awvalid && s_axi_awready) begin
                        aw_q <= s_axi_awaddr;
                        aw_have_q <= 1'b1;
                    end
                    if (s_axi_wvalid && s_axi_wready) begin
                        w_q <= s_axi_wdata;
                        wstrb0_q <= s_axi_wstrb[0];
                        w_have_q <= 1'b1;
                    end
                    if (wr_fire) begin
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_mapped ? `MCF_RESP_OKAY : `MCF_RESP_SLVERR;
                        aw_have_q <= 1'b0;
                        w_have_q <= 1'b0;
                        wst_q <= MCF_WRESP;
                    end
                end
                MCF_WRESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wst_q <= MCF_IDLE;
                    end
                end
                default: wst_q <= MCF_IDLE;
            endcase
        end
    end

    // decode of a completed write; strobes ignored on trigger registers
    always_comb begin
        fl_ng = wr_fire && aw_q == `MCF_OFF_FLUSH_NG;
        fl_all = wr_fire && aw_q == `MCF_OFF_FLUSH_ALL;
        fl_one = wr_fire && aw_q == `MCF_OFF_FLUSH_ONE_HI && !ab_s2_q;
        ld_ent = wr_fire && aw_q == `MCF_OFF_TLB_LOAD;
        wr_mapped = fl_ng || fl_all || ld_ent || (aw_q == `MCF_OFF_FLUSH_ONE_HI)
            || aw_q == `MCF_OFF_FLUSH_ONE_LO || aw_q == `MCF_OFF_SPACE_NUM
            || aw_q == `MCF_OFF_MEM_CTRL || aw_q == `MCF_OFF_CACHE_MODE;
    end
    // flush va: low word holds va 31:13, high word holds va 42:32
    assign one_vpn = {w_q[10:0], one_lo_q[31:13]};

    // control registers; timeout reset deliberately not used here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_ctrl_q <= `MCF_MC_RESET;
            cache_mode_q <= `MCF_CM_RESET;
            space_number_q <= 7'h00;
            one_lo_q <= 32'h0000_0000;
        end else if (wr_fire) begin
            if (aw_q == `MCF_OFF_MEM_CTRL && wstrb0_q)
                mem_ctrl_q <= w_q[5:0];
            if (aw_q == `MCF_OFF_CACHE_MODE && wstrb0_q)
                cache_mode_q <= w_q[3:0];
            if (aw_q == `MCF_OFF_SPACE_NUM)
                space_number_q <= w_q[31:25]; // space number bits 63:57 sit in upper word
            if (aw_q == `MCF_OFF_FLUSH_ONE_LO)
                one_lo_q <= w_q;
        end
    end

    // per-entry match and flush; flush lands in the write cycle so next lookup sees it
    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_ent
            assign one_match[g] = valid_q[g] && vpn_q[g] == one_vpn
                && (glob_q[g] || ent_space_q[g] == space_number_q);
            assign hit_vec[g] = valid_q[g] && vpn_q[g] == lookup_va[42:13]
                && (glob_q[g] || ent_space_q[g] == space_number_q);
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    valid_q[g] <= 1'b0;
                    glob_q[g] <= 1'b0;
                    vpn_q[g] <= 30'h0;
                    ent_space_q[g] <= 7'h0;
                    pfn_q[g] <= 27'h0;
                end else if (fl_all) begin
                    valid_q[g] <= 1'b0;
                end else if (fl_ng && !glob_q[g]) begin
                    valid_q[g] <= 1'b0;
                end else if (fl_one && one_match[g]) begin
                    valid_q[g] <= 1'b0;
                end else if (ld_ent && victim_q == 6'(g)) begin
                    valid_q[g] <= 1'b1;
                    glob_q[g] <= w_q[31];
                    vpn_q[g] <= {11'h0, one_lo_q[31:13]};
                    ent_space_q[g] <= space_number_q;
                    pfn_q[g] <= {8'h0, w_q[18:0]};
                end
            end
        end
    endgenerate

    // victim pointer advances per load, restarts on full flush
    always_ff @(posedge aclk) begin
        if (!aresetn)
            victim_q <= 6'h00;
        else if (fl_all)
            victim_q <= 6'h00;
        else if (ld_ent)
            victim_q <= victim_q + 6'h01;
    end

    // translation path: superpage first, then tlb
    always_comb begin
        logic [26:0] pfn;
        pfn = 27'h0;
        lookup_superpage = 1'b0;
        for (int i = 0; i < NE; i++)
            if (hit_vec[i])
                pfn = pfn_q[i];
        if (lookup_kernel && mem_ctrl_q[`MCF_MC_SP1] && lookup_va[42:41] == `MCF_SP1_TAG) begin
            lookup_superpage = 1'b1;
            pfn = lookup_va[39:13];
        end else if (lookup_kernel && mem_ctrl_q[`MCF_MC_SP0] && lookup_va[42:30] == `MCF_SP0_TAG) begin
            lookup_superpage = 1'b1;
            pfn = {10'h000, lookup_va[29:13]};
        end
        lookup_hit = lookup_superpage || (|hit_vec);
        lookup_pa = {pfn, lookup_va[12:0]};
        lookup_pa[2] = lookup_va[2] ^ (mem_ctrl_q[`MCF_MC_BIG_END] && lookup_longword);
    end

    // formatted fault address, short format picked by sp0
    always_comb begin
        if (mem_ctrl_q[`MCF_MC_SP0])
            formatted_fault_address = {vptb_base[63:30], 8'h00, fault_va[31:13], 3'h0};
        else
            formatted_fault_address = {vptb_base[63:33], fault_va[42:13], 3'h0};
    end

    // cache mode controls and the ebox endian bit from memory control
    assign ebox_big_endian = mem_ctrl_q[`MCF_MC_EBOX_BIG];
    assign cache_active = cache_mode_q[`MCF_CM_ENA] && !hd_s2_q;
    assign cache_force_hit = cache_mode_q[`MCF_CM_FHIT];
    assign parity_corrupt_inject = cache_mode_q[`MCF_CM_BADPAR];
    assign parity_err_report = parity_err_raw && !cache_mode_q[`MCF_CM_PERR_OFF];

    // read channel, one cycle answer held until rready
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MCF_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MCF_RESP_OKAY;
            case (s_axi_araddr)
                `MCF_OFF_MEM_CTRL: s_axi_rdata <= {26'h0, mem_ctrl_q};
                `MCF_OFF_CACHE_MODE: s_axi_rdata <= {28'h0, cache_mode_q};
                `MCF_OFF_SPACE_NUM: s_axi_rdata <= {space_number_q, 25'h0};
                `MCF_OFF_STATUS: s_axi_rdata <= {18'h0, victim_q, 1'b0, 7'(($countones(valid_q)))};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `MCF_RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // unused pin kept for the timeout reset of sibling blocks
    logic unused_ok;
    assign unused_ok = timeout_reset;

    mcf_flush_all_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fl_all |=> valid_q == '0 && victim_q == 6'h00) else $error("full flush left entries");
    mcf_flush_ng_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fl_ng && !fl_all |=> (valid_q & ~glob_q) == '0) else $error("nonglobal entry survived");
    mcf_keep_glob_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fl_ng && !fl_all |=> (valid_q & glob_q) == $past(valid_q & glob_q)) else $error("global lost");
    mcf_flush_one_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fl_one && !fl_all && !fl_ng |=> (valid_q & $past(one_match)) == '0) else $error("single flush missed");
    mcf_abort_a: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && ab_s2_q |-> !fl_one) else $error("flush not aborted");
    mcf_super_kern_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lookup_superpage |-> lookup_kernel) else $error("superpage outside kernel");
    mcf_sp0_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lookup_superpage && !(mem_ctrl_q[2] && lookup_va[42:41] == 2'h2)
        |-> lookup_pa[39:30] == 10'h0) else $error("sp0 high bits nonzero");
    mcf_big_end_a: assert property (@(posedge aclk) disable iff (!aresetn)
        mem_ctrl_q[0] && lookup_longword |-> lookup_pa[2] != lookup_va[2]) else $error("pa2 not inverted");
    mcf_cache_ena_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cache_active |-> cache_mode_q[0] && !hd_s2_q) else $error("cache active wrongly");
    mcf_perr_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cache_mode_q[3] |-> !parity_err_report) else $error("parity reported while off");
    mcf_reset_clr_a: assert property (@(posedge aclk)
        !aresetn |=> mem_ctrl_q == 6'h00 && cache_mode_q == 4'h0) else $error("reset did not clear");
endmodule : mcf_memctl

// ===== dv/mcf_pipe_model.sv
// Purpose: pipeline-side model issuing privileged register writes and reads
// Assumes: axi4-lite master, one write and one read at most in flight
// Notes: stuck rises when a handshake runs past its bound
`timescale 1ns/1ps
module mcf_pipe_model (
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic rvalid,
    output logic rready,
    output logic stuck
);
    // idle bus from time zero
    initial begin
        {awaddr, araddr, wdata} = 48'h0;
        {awvalid, wvalid, bready, arvalid, rready, stuck} = 6'h0;
    end

    // integer register writes only, never a float store
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            n++;
            // released lines show inverted data, not the old value
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!(bvalid && bready) && n < 100);
        bready <= 1'b0;
        if (n >= 100) stuck <= 1'b1;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!(rvalid && rready) && n < 100);
        rready <= 1'b0;
        if (n >= 100) stuck <= 1'b1;
    endtask : rd
endmodule : mcf_pipe_model

// ===== dv/dtlb_flush_dcache_mode_tb_top.sv
// Purpose: self-checking bench for the memory-unit control block
// Assumes: reads and writes go through the pipeline model
// Notes: expected bus results queue up and a monitor pops them
`timescale 1ns/1ps
`include "mcf_consts.svh"
`define CHK(a, e, m) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("[FAIL] %0t %s", $time, m); end end
module dtlb_flush_dcache_mode_tb_top;
    logic aclk, aresetn, timeout_reset, flush_abort, lookup_kernel, lookup_longword, cache_hw_disable, parity_err_raw;
    logic [42:0] lookup_va, fault_va;
    logic [63:0] vptb_base, formatted_fault_address;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, seed;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, stuck;
    logic [1:0] bresp, rresp;
    logic lookup_hit, lookup_superpage, ebox_big_endian, cache_active, cache_force_hit, parity_corrupt_inject;
    logic parity_err_report;
    logic [39:0] lookup_pa;
    logic [5:0] mc;
    logic [3:0] cm;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    int error_cnt, n_checks, i;

    mcf_memctl i_dut (.aclk(aclk), .aresetn(aresetn), .timeout_reset(timeout_reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .flush_abort(flush_abort), .lookup_va(lookup_va), .lookup_kernel(lookup_kernel),
        .lookup_longword(lookup_longword), .lookup_hit(lookup_hit), .lookup_superpage(lookup_superpage),
        .lookup_pa(lookup_pa), .vptb_base(vptb_base), .fault_va(fault_va),
        .formatted_fault_address(formatted_fault_address), .ebox_big_endian(ebox_big_endian),
        .cache_hw_disable(cache_hw_disable), .cache_active(cache_active), .cache_force_hit(cache_force_hit),
        .parity_corrupt_inject(parity_corrupt_inject), .parity_err_raw(parity_err_raw),
        .parity_err_report(parity_err_report));

    mcf_pipe_model i_pipe (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rvalid(rvalid), .rready(rready), .stuck(stuck));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : wrap_up

    task automatic w(input logic [7:0] a, input logic [31:0] d);
        bq.push_back(`MCF_RESP_OKAY);
        i_pipe.wr(a, d);
    endtask : w

    task automatic r(input logic [7:0] a, input logic [33:0] e);
        rq.push_back(e);
        i_pipe.rd(a);
    endtask : r

    // drive a lookup at an edge, look once it has settled
    task automatic lk(input logic [42:0] va, input logic kern, input logic lw);
        @(posedge aclk);
        lookup_va <= va;
        lookup_kernel <= kern;
        lookup_longword <= lw;
        @(negedge aclk);
    endtask : lk

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // monitor pops the oldest note whenever a response is taken
    always @(posedge aclk) begin
        if (rvalid === 1'b1 && rready === 1'b1) `CHK({rresp, rdata}, rq.pop_front(), "read result")
        if (bvalid === 1'b1 && bready === 1'b1) `CHK(bresp, bq.pop_front(), "write response")
    end

    always @(posedge stuck) begin
        error_cnt++;
        wrap_up();
    end

    initial begin
        {aresetn, timeout_reset, flush_abort, lookup_kernel, lookup_longword, cache_hw_disable} = 6'h0;
        {lookup_va, fault_va, vptb_base, parity_err_raw} = 151'h0;
        seed = 32'h0001_1b1c;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        r(`MCF_OFF_MEM_CTRL, 34'h0);
        r(`MCF_OFF_CACHE_MODE, 34'h0);
        r(8'h24, {`MCF_RESP_SLVERR, 32'h0});
        // unmapped write must be refused with an error response
        bq.push_back(`MCF_RESP_SLVERR);
        i_pipe.wr(8'h24, seed);
        // random control values, reserved bits kept clear
        for (i = 0; i < 4; i++) begin
            seed = lfsr(seed);
            mc = {1'b0, i[0], 1'b0, seed[2:0]};
            w(`MCF_OFF_MEM_CTRL, {26'h0, mc});
            r(`MCF_OFF_MEM_CTRL, {8'h0, 20'h0, mc});
            `CHK(ebox_big_endian, mc[4], "ebox endian")
        end
        w(`MCF_OFF_MEM_CTRL, 32'h7);
        vptb_base <= {seed, ~seed};
        fault_va <= {11'h3a, seed};
        lk({3'b101, seed, 8'h5a}, 1'b1, 1'b1);
        `CHK(lookup_superpage, 1'b1, "sp1 map")
        `CHK(lookup_pa[39:13], lookup_va[39:13], "sp1 pa")
        `CHK(lookup_pa[2], ~lookup_va[2], "longword swap")
        `CHK(formatted_fault_address[21:3], fault_va[31:13], "short pte va")
        `CHK(formatted_fault_address[63:30], vptb_base[63:30], "short pte base")
        lk(lookup_va, 1'b0, 1'b1);
        `CHK(lookup_superpage, 1'b0, "user superpage")
        lk({13'h1ffe, seed[29:0]}, 1'b1, 1'b0);
        `CHK(lookup_pa[39:30], 10'h0, "sp0 high")
        `CHK(lookup_pa[29:13], lookup_va[29:13], "sp0 pa")
        `CHK(lookup_pa[2], lookup_va[2], "no swap")
        w(`MCF_OFF_MEM_CTRL, 32'h0);
        @(negedge aclk);
        `CHK(formatted_fault_address[32:3], fault_va[42:13], "long pte va")
        // every cache mode against the hardware disable pin
        for (i = 0; i < 16; i++) begin
            cm = i[3:0];
            w(`MCF_OFF_CACHE_MODE, {28'h0, cm});
            cache_hw_disable <= i[1] ^ i[3];
            parity_err_raw <= ~i[0];
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            `CHK(cache_active, cm[0] & ~cache_hw_disable, "cache active")
            `CHK(cache_force_hit, cm[1], "force hit")
            `CHK(parity_corrupt_inject, cm[2], "bad parity")
            `CHK(parity_err_report, parity_err_raw & ~cm[3], "parity report")
        end
        w(`MCF_OFF_MEM_CTRL, 32'h13);
        @(posedge aclk);
        timeout_reset <= 1'b1;
        repeat (3) @(posedge aclk);
        timeout_reset <= 1'b0;
        r(`MCF_OFF_MEM_CTRL, 34'h13);
        r(`MCF_OFF_CACHE_MODE, 34'hf);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        r(`MCF_OFF_MEM_CTRL, 34'h0);
        r(`MCF_OFF_CACHE_MODE, 34'h0);
        // three entries, the middle one global, space number 5
        w(`MCF_OFF_SPACE_NUM, 32'h0a00_0000);
        for (i = 1; i < 4; i++) begin
            w(`MCF_OFF_FLUSH_ONE_LO, {i[18:0], 13'h0});
            w(`MCF_OFF_TLB_LOAD, {i == 2, 12'h0, seed[18:0]});
        end
        r(`MCF_OFF_STATUS, 34'h303);
        lk({30'h1, 13'h0}, 1'b0, 1'b0);
        `CHK(lookup_hit, 1'b1, "loaded hit")
        @(posedge aclk);
        flush_abort <= 1'b1;
        repeat (4) @(posedge aclk);
        w(`MCF_OFF_FLUSH_ONE_LO, {19'h3, 13'h0});
        w(`MCF_OFF_FLUSH_ONE_HI, 32'h0);
        r(`MCF_OFF_STATUS, 34'h303);
        flush_abort <= 1'b0;
        repeat (4) @(posedge aclk);
        w(`MCF_OFF_FLUSH_ONE_HI, 32'h0);
        r(`MCF_OFF_STATUS, 34'h302);
        w(`MCF_OFF_FLUSH_NG, seed);
        r(`MCF_OFF_STATUS, 34'h301);
        lk({30'h1, 13'h0}, 1'b0, 1'b0);
        `CHK(lookup_hit, 1'b0, "flushed miss")
        w(`MCF_OFF_SPACE_NUM, 32'h1200_0000);
        w(`MCF_OFF_FLUSH_ONE_LO, {19'h2, 13'h0});
        w(`MCF_OFF_FLUSH_ONE_HI, 32'h0);
        r(`MCF_OFF_STATUS, 34'h300);
        w(`MCF_OFF_FLUSH_ALL, ~seed);
        r(`MCF_OFF_STATUS, 34'h0);
        repeat (10) @(posedge aclk);
        `CHK(rq.size() + bq.size(), 0, "pending notes")
        wrap_up();
    end
endmodule : dtlb_flush_dcache_mode_tb_top
